// file: prs_register_set.v
// processor architectural register set
`timescale 1ns/1ns
`default_nettype none
`include "prs_consts.vh"

module prs_register_set #(
    parameter [31:0] VERSION_ID = `PRS_VERSION // arbitrary value
) (
    input wire i_ref_clk,
    input wire i_rst,
    // explicit register access (move to/from)
    input wire i_acc_valid,
    input wire i_acc_write,
    input wire [1:0] i_acc_kind,
    input wire [9:0] i_acc_num,
    input wire [31:0] i_acc_wdata,
    output wire [31:0] o_acc_rdata,
    output wire o_acc_done,
    output wire o_priv_fault,
    output wire o_acc_illegal,
    // integer operand file
    input wire [4:0] i_gpr_ra,
    input wire [4:0] i_gpr_rb,
    output wire [31:0] o_gpr_a,
    output wire [31:0] o_gpr_b,
    input wire i_gpr_we,
    input wire [4:0] i_gpr_wa,
    input wire [31:0] i_gpr_wd,
    // float operand file
    input wire [4:0] i_fpr_ra,
    output wire [63:0] o_fpr_a,
    input wire i_fpr_we,
    input wire [4:0] i_fpr_wa,
    input wire [63:0] i_fpr_wd,
    // condition flags field update
    input wire i_cr_we,
    input wire [2:0] i_cr_field,
    input wire [3:0] i_cr_val,
    output wire [31:0] o_cr,
    // integer exception register update
    input wire i_xer_we,
    input wire i_xer_ov,
    input wire i_xer_ca,
    input wire i_xer_bc_we,
    input wire [6:0] i_xer_bc,
    output wire [31:0] o_xer,
    // float status control update
    input wire i_float_status_control_we,
    input wire [31:0] i_float_status_control_wd,
    output wire [31:0] o_float_status_control,
    // branch link and count
    input wire i_link_we,
    input wire [31:0] i_link_addr,
    output wire [31:0] o_link,
    input wire i_bc_dec,
    output wire o_ctr_zero,
    // data faults
    input wire i_dfault,
    input wire [31:0] i_dfault_addr,
    input wire [31:0] i_dfault_cause,
    // exception entry and return
    input wire i_exc_take,
    input wire [31:0] i_exc_addr,
    input wire i_rfi,
    output wire o_rfi_go,
    output wire [31:0] o_rfi_pc,
    // machine state, external access enable and decrementer exception outputs
    output wire [31:0] o_msr,
    output wire o_user_mode,
    output wire o_sleep_allow,
    output wire o_perf_mark,
    output wire o_ext_access_en,
    output wire o_dec_exc,
    // segment lookups
    input wire [3:0] i_data_seg,
    output wire [31:0] o_data_seg,
    input wire [3:0] i_fetch_seg,
    output wire [31:0] o_fetch_seg
);

reg [31:0] gpr_q [0:31]; // RULE3
reg [63:0] fpr_q [0:31]; // RULE2
reg [31:0] seg_main_q [0:15]; // RULE5
reg [31:0] seg_shadow_q [0:15];
reg [31:0] bat_q [0:15]; // RULE10
reg [31:0] sprg_q [0:3];
reg [31:0] cr_q, xer_q, float_status_control_q, msr_q;
reg [31:0] lr_q, ctr_q, dar_q, data_fault_cause_q, dec_q; // RULE9
reg [31:0] page_table_descriptor_q, resume_address_save_q, resume_state_save_q, ear_q, data_watch_address_q;
reg [63:0] tb_q;
reg [31:0] rdata_q, gpr_a_q, gpr_b_q, data_seg_q, fetch_seg_q;
reg [63:0] fpr_a_q;
reg done_q, fault_q, illegal_q, ctr_zero_q, rfi_go_q, dec_exc_q;
reg [31:0] rfi_pc_q;
reg [31:0] ctr_d;
wire user_mode;
wire priv_ok;
wire known;
wire do_write;
wire do_read;
wire spr_write;
wire seg_write;
wire [3:0] seg_idx;

// user-level special registers
function spr_user_ok;
    input [9:0] num;
    input wr;
    begin
        case (num)
            `PRS_SPR_XER, `PRS_SPR_LR, `PRS_SPR_CTR,
            `PRS_SPR_DATA_FAULT_CAUSE, `PRS_SPR_DAR: spr_user_ok = 1'b1;
            `PRS_SPR_TBL_R, `PRS_SPR_TBU_R: spr_user_ok = ~wr; // RULE18
            default: spr_user_ok = 1'b0;
        endcase
    end
endfunction

// number falls in the block translation range
function spr_is_block;
    input [9:0] num;
    begin
        spr_is_block = (num >= `PRS_SPR_BAT_LO) &&
            (num <= `PRS_SPR_BAT_HI);
    end
endfunction

// number falls in the scratch register range
function spr_is_scratch;
    input [9:0] num;
    begin
        spr_is_scratch = (num >= `PRS_SPR_SPRG0) &&
            (num <= `PRS_SPR_SPRG3);
    end
endfunction

// machine state on exception entry: supervisor level, sleep off
function [31:0] entry_state;
    input [31:0] cur;
    begin
        entry_state = cur;
        entry_state[`PRS_MSR_PR] = 1'b0;
        entry_state[`PRS_MSR_POW] = 1'b0;
    end
endfunction

// special register number is implemented
function spr_known;
    input [9:0] num;
    begin
        case (num)
            `PRS_SPR_XER, `PRS_SPR_LR, `PRS_SPR_CTR, `PRS_SPR_DATA_FAULT_CAUSE,
            `PRS_SPR_DAR, `PRS_SPR_DEC, `PRS_SPR_PAGE_TABLE_DESCRIPTOR, `PRS_SPR_RESUME_ADDRESS_SAVE,
            `PRS_SPR_RESUME_STATE_SAVE, `PRS_SPR_TBL_R, `PRS_SPR_TBU_R,
            `PRS_SPR_EAR, `PRS_SPR_TBL_W, `PRS_SPR_TBU_W,
            `PRS_SPR_PVR, `PRS_SPR_DATA_WATCH_ADDRESS: spr_known = 1'b1;
            default: spr_known = spr_is_scratch(num) || spr_is_block(num);
        endcase
    end
endfunction

assign user_mode = msr_q[`PRS_MSR_PR];
assign known = (i_acc_kind != `PRS_ACC_SPR) || spr_known(i_acc_num);
assign priv_ok = ~user_mode || (i_acc_kind == `PRS_ACC_CR) ||
    ((i_acc_kind == `PRS_ACC_SPR) &&
    spr_user_ok(i_acc_num, i_acc_write)); // RULE8
assign do_write = i_acc_valid & i_acc_write & priv_ok & known; // RULE23
// decoded access strobes
assign do_read = i_acc_valid & ~i_acc_write & priv_ok & known;
assign spr_write = do_write & (i_acc_kind == `PRS_ACC_SPR);
assign seg_write = do_write & (i_acc_kind == `PRS_ACC_SEG);
assign seg_idx = i_acc_num[3:0];

// read path and access status
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        rdata_q <= 32'h0000_0000;
        done_q <= 1'b0;
        fault_q <= 1'b0;
        illegal_q <= 1'b0;
    end else begin
        done_q <= i_acc_valid;
        fault_q <= i_acc_valid & known & ~priv_ok; // RULE23
        illegal_q <= i_acc_valid & ~known;
        rdata_q <= 32'h0000_0000;
        if (do_read) begin
            case (i_acc_kind)
                `PRS_ACC_MSR: rdata_q <= msr_q;
                `PRS_ACC_SEG: rdata_q <= seg_main_q[seg_idx]; // RULE7
                `PRS_ACC_CR: rdata_q <= cr_q;
                default: begin
                    case (i_acc_num)
                        `PRS_SPR_XER: rdata_q <= xer_q;
                        `PRS_SPR_LR: rdata_q <= lr_q;
                        `PRS_SPR_CTR: rdata_q <= ctr_q;
                        `PRS_SPR_DATA_FAULT_CAUSE: rdata_q <= data_fault_cause_q;
                        `PRS_SPR_DAR: rdata_q <= dar_q;
                        `PRS_SPR_DEC: rdata_q <= dec_q;
                        `PRS_SPR_PAGE_TABLE_DESCRIPTOR: rdata_q <= page_table_descriptor_q;
                        `PRS_SPR_RESUME_ADDRESS_SAVE: rdata_q <= resume_address_save_q;
                        `PRS_SPR_RESUME_STATE_SAVE: rdata_q <= resume_state_save_q;
                        `PRS_SPR_TBL_R: rdata_q <= tb_q[31:0]; // RULE18
                        `PRS_SPR_TBU_R: rdata_q <= tb_q[63:32];
                        // write-side numbers read back the same halves
                        `PRS_SPR_TBL_W: rdata_q <= tb_q[31:0]; // RULE18
                        `PRS_SPR_TBU_W: rdata_q <= tb_q[63:32];
                        `PRS_SPR_EAR: rdata_q <= ear_q;
                        `PRS_SPR_PVR: rdata_q <= VERSION_ID; // RULE15
                        `PRS_SPR_DATA_WATCH_ADDRESS: rdata_q <= data_watch_address_q;
                        default: begin
                            if (spr_is_block(i_acc_num))
                                rdata_q <= bat_q[i_acc_num[3:0]];
                            else
                                rdata_q <= sprg_q[i_acc_num[1:0]];
                        end
                    endcase
                end
            endcase
        end
    end
end

// operand files, no reset on data storage
always @(posedge i_ref_clk) begin
    if (i_gpr_we)
        gpr_q[i_gpr_wa] <= i_gpr_wd; // RULE3
    if (i_fpr_we)
        fpr_q[i_fpr_wa] <= i_fpr_wd; // RULE2
    gpr_a_q <= gpr_q[i_gpr_ra];
    gpr_b_q <= gpr_q[i_gpr_rb];
    fpr_a_q <= fpr_q[i_fpr_ra];
    if (seg_write) begin
        seg_main_q[seg_idx] <= i_acc_wdata; // RULE6
        seg_shadow_q[seg_idx] <= i_acc_wdata;
    end
    data_seg_q <= seg_main_q[i_data_seg]; // RULE5
    fetch_seg_q <= seg_shadow_q[i_fetch_seg]; // RULE6
    if (spr_write) begin
        if (spr_is_block(i_acc_num))
            bat_q[i_acc_num[3:0]] <= i_acc_wdata; // RULE10
        if (spr_is_scratch(i_acc_num))
            sprg_q[i_acc_num[1:0]] <= i_acc_wdata;
    end
end

// loop count next value, event wins over explicit write
always @* begin
    ctr_d = ctr_q;
    if (spr_write && i_acc_num == `PRS_SPR_CTR)
        ctr_d = i_acc_wdata;
    if (i_bc_dec)
        ctr_d = ctr_q - 32'h0000_0001; // RULE11
end

// control, status and special registers
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        cr_q <= `PRS_RST_WORD;
        xer_q <= `PRS_RST_WORD;
        float_status_control_q <= `PRS_RST_WORD;
        msr_q <= `PRS_RST_WORD;
        lr_q <= `PRS_RST_WORD;
        ctr_q <= `PRS_RST_WORD;
        dar_q <= `PRS_RST_WORD;
        data_fault_cause_q <= `PRS_RST_WORD;
        page_table_descriptor_q <= `PRS_RST_WORD;
        resume_address_save_q <= `PRS_RST_WORD;
        resume_state_save_q <= `PRS_RST_WORD;
        ear_q <= `PRS_RST_WORD;
        data_watch_address_q <= `PRS_RST_WORD;
        ctr_zero_q <= 1'b0;
        rfi_go_q <= 1'b0;
        rfi_pc_q <= `PRS_RST_WORD;
    end else begin
        ctr_q <= ctr_d;
        ctr_zero_q <= i_bc_dec & (ctr_d == 32'h0000_0000); // RULE11
        rfi_go_q <= 1'b0;
        // explicit writes
        if (do_write) begin
            case (i_acc_kind)
                `PRS_ACC_MSR: msr_q <= i_acc_wdata;
                `PRS_ACC_CR: cr_q <= i_acc_wdata;
                `PRS_ACC_SPR: begin
                    case (i_acc_num)
                        `PRS_SPR_XER: xer_q <= i_acc_wdata;
                        `PRS_SPR_LR: lr_q <= i_acc_wdata;
                        `PRS_SPR_DATA_FAULT_CAUSE: data_fault_cause_q <= i_acc_wdata;
                        `PRS_SPR_DAR: dar_q <= i_acc_wdata;
                        `PRS_SPR_PAGE_TABLE_DESCRIPTOR: page_table_descriptor_q <= i_acc_wdata;
                        `PRS_SPR_RESUME_ADDRESS_SAVE: resume_address_save_q <= i_acc_wdata;
                        `PRS_SPR_RESUME_STATE_SAVE: resume_state_save_q <= i_acc_wdata;
                        `PRS_SPR_EAR: ear_q <= i_acc_wdata; // RULE21
                        `PRS_SPR_DATA_WATCH_ADDRESS: data_watch_address_q <= i_acc_wdata;
                        default: ; // RULE15
                    endcase
                end
                default: ;
            endcase
        end
        // execution unit updates take priority
        if (i_cr_we)
            cr_q[{i_cr_field, 2'b00} +: 4] <= i_cr_val; // RULE1
        if (i_xer_we) begin
            xer_q[`PRS_XER_OV] <= i_xer_ov; // RULE19
            xer_q[`PRS_XER_CA] <= i_xer_ca;
            xer_q[`PRS_XER_SO] <= xer_q[`PRS_XER_SO] | i_xer_ov;
        end
        if (i_xer_bc_we)
            xer_q[6:0] <= i_xer_bc; // RULE19
        if (i_float_status_control_we)
            float_status_control_q <= i_float_status_control_wd; // RULE20
        if (i_link_we)
            lr_q <= i_link_addr; // RULE12
        if (i_dfault) begin
            dar_q <= i_dfault_addr; // RULE13
            data_fault_cause_q <= i_dfault_cause;
        end
        // exception entry wins over return
        if (i_exc_take) begin
            resume_address_save_q <= i_exc_addr; // RULE16
            resume_state_save_q <= msr_q; // RULE4 RULE17
            msr_q <= entry_state(msr_q); // RULE4
        end else if (i_rfi) begin
            msr_q <= resume_state_save_q; // RULE4 RULE17
            rfi_pc_q <= resume_address_save_q; // RULE16
            rfi_go_q <= 1'b1;
        end
    end
end

// free-running time base and down counter; an explicit write loads them
always @(posedge i_ref_clk) begin
    if (i_rst) begin
        tb_q <= 64'h0000_0000_0000_0000;
        dec_q <= `PRS_RST_WORD;
        dec_exc_q <= 1'b0;
    end else begin
        tb_q <= tb_q + 64'h0000_0000_0000_0001;
        dec_q <= dec_q - 32'h0000_0001; // RULE14
        dec_exc_q <= (dec_q == 32'h0000_0000); // RULE14
        if (spr_write && i_acc_num == `PRS_SPR_DEC)
            dec_q <= i_acc_wdata;
        if (spr_write && i_acc_num == `PRS_SPR_TBL_W)
            tb_q[31:0] <= i_acc_wdata; // RULE18
        if (spr_write && i_acc_num == `PRS_SPR_TBU_W)
            tb_q[63:32] <= i_acc_wdata;
    end
end

assign o_acc_rdata = rdata_q;
assign o_acc_done = done_q;
assign o_priv_fault = fault_q;
assign o_acc_illegal = illegal_q;
assign o_gpr_a = gpr_a_q;
assign o_gpr_b = gpr_b_q;
assign o_fpr_a = fpr_a_q;
assign o_cr = cr_q;
assign o_xer = xer_q;
assign o_float_status_control = float_status_control_q;
assign o_link = lr_q; // RULE12
assign o_ctr_zero = ctr_zero_q;
assign o_rfi_go = rfi_go_q;
assign o_rfi_pc = rfi_pc_q;
assign o_msr = msr_q;
assign o_user_mode = msr_q[`PRS_MSR_PR];
assign o_sleep_allow = msr_q[`PRS_MSR_POW]; // RULE22
assign o_perf_mark = msr_q[`PRS_MSR_PM]; // RULE22
assign o_ext_access_en = ear_q[`PRS_EAR_EN]; // RULE21
assign o_dec_exc = dec_exc_q;
assign o_data_seg = data_seg_q;
assign o_fetch_seg = fetch_seg_q;

endmodule // prs_register_set
`default_nettype wire

// file: prs_consts.vh
// constants for the processor register set
// Summary of operation
// RULE1: condition flags are eight 4-bit fields, updated by operations, read for branching.
// RULE2: float operand file holds 32 entries of 64 bits each.
// RULE3: integer operand file holds 32 entries used as sources and results.
// RULE4: machine state is saved on exception entry and restored on return.
// RULE5: sixteen 32-bit segment entries split the 4-Gbyte space into 256-Mbyte segments.
// RULE6: segment writes update the data main array and fetch shadow array together.
// RULE7: segment reads return the data main array copy.
// RULE8: special register access depends on the user mode bit in machine state.
// RULE9: every special-purpose register is 32 bits wide.
// RULE10: sixteen block translation registers: four data and four fetch upper/lower pairs.
// RULE11: loop count register decrements then is tested on branch-and-count.
// RULE12: branch link register captures return address and supplies branch target.
// RULE13: alignment or data storage fault loads fault address and fault cause.
// RULE14: down counter is 32 bits, decrements continually, schedules decrementer exceptions.
// RULE15: version register is read only; writes leave it unchanged.
// RULE16: resume address save captures restart address; return resumes there.
// RULE17: resume state save captures machine state; return restores it.
// RULE18: time base is 64 bits in two halves; user reads, supervisor writes.
// RULE19: integer exception register holds summary overflow, carry, overflow, byte count.
// RULE20: float status control holds flags, summaries, enables and rounding mode.
// RULE21: external access control register gates external control word instructions.
// RULE22: machine state has sleep allow bit and performance mark bit.
// RULE23: user access to supervisor register is not performed and raises privilege fault.
`ifndef PRS_CONSTS_VH
`define PRS_CONSTS_VH

`define PRS_ACC_SPR 2'h0
`define PRS_ACC_MSR 2'h1
`define PRS_ACC_SEG 2'h2
`define PRS_ACC_CR 2'h3

`define PRS_SPR_XER 10'h001
`define PRS_SPR_LR 10'h008
`define PRS_SPR_CTR 10'h009
`define PRS_SPR_DATA_FAULT_CAUSE 10'h012
`define PRS_SPR_DAR 10'h013
`define PRS_SPR_DEC 10'h016
`define PRS_SPR_PAGE_TABLE_DESCRIPTOR 10'h019
`define PRS_SPR_RESUME_ADDRESS_SAVE 10'h01A
`define PRS_SPR_RESUME_STATE_SAVE 10'h01B
`define PRS_SPR_TBL_R 10'h10C
`define PRS_SPR_TBU_R 10'h10D
`define PRS_SPR_SPRG0 10'h110
`define PRS_SPR_SPRG3 10'h113
`define PRS_SPR_EAR 10'h11A
`define PRS_SPR_TBL_W 10'h11C
`define PRS_SPR_TBU_W 10'h11D
`define PRS_SPR_PVR 10'h11F
`define PRS_SPR_BAT_LO 10'h210
`define PRS_SPR_BAT_HI 10'h21F
`define PRS_SPR_DATA_WATCH_ADDRESS 10'h3F5

`define PRS_MSR_PR 14
`define PRS_MSR_POW 18
`define PRS_MSR_PM 2
`define PRS_EAR_EN 31

`define PRS_XER_SO 31
`define PRS_XER_OV 30
`define PRS_XER_CA 29

`define PRS_RST_WORD 32'h0000_0000
`define PRS_VERSION 32'h0001_0000

`endif

// file: prs_register_set_sva.sv
// assertions on the register set ports
`timescale 1ns/1ns
`default_nettype none
`include "prs_consts.vh"
module prs_register_set_sva #(
    parameter [31:0] VERSION_ID = 32'h0
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_acc_valid,
    input wire logic i_acc_write,
    input wire logic [1:0] i_acc_kind,
    input wire logic [9:0] i_acc_num,
    input wire logic [31:0] o_acc_rdata,
    input wire logic o_priv_fault,
    input wire logic i_cr_we,
    input wire logic [2:0] i_cr_field,
    input wire logic [3:0] i_cr_val,
    input wire logic [31:0] o_cr,
    input wire logic i_xer_we,
    input wire logic i_xer_ov,
    input wire logic i_xer_ca,
    input wire logic [31:0] o_xer,
    input wire logic i_link_we,
    input wire logic [31:0] i_link_addr,
    input wire logic [31:0] o_link,
    input wire logic i_bc_dec,
    input wire logic o_ctr_zero,
    input wire logic i_exc_take,
    input wire logic [31:0] i_exc_addr,
    input wire logic i_rfi,
    input wire logic o_rfi_go,
    input wire logic [31:0] o_rfi_pc,
    input wire logic o_user_mode,
    input wire logic o_sleep_allow
);
    wire spr_rd = i_acc_valid && !i_acc_write && i_acc_kind == `PRS_ACC_SPR;
    wire tbl_rd = spr_rd && i_acc_num == `PRS_SPR_TBL_R;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);
    AST_CR_FIELD: assert property (i_cr_we |=>
        o_cr[4*$past(i_cr_field) +: 4] == $past(i_cr_val))
        else $error("condition field not loaded");
    AST_XER_BITS: assert property (i_xer_we |=>
        o_xer[30] == $past(i_xer_ov) && o_xer[29] == $past(i_xer_ca)
        && (o_xer[31] || !$past(i_xer_ov)))
        else $error("overflow or carry bits wrong");
    AST_LINK: assert property (i_link_we |=>
        o_link == $past(i_link_addr)) else $error("link not captured");
    AST_CTR_ZERO: assert property (o_ctr_zero |-> $past(i_bc_dec))
        else $error("count zero flag without branch-and-count");
    AST_PRIV: assert property (
        i_acc_valid && o_user_mode && i_acc_kind == `PRS_ACC_MSR
        |=> o_priv_fault && o_acc_rdata == 32'h0)
        else $error("user access to machine state not refused");
    AST_EXC: assert property (i_exc_take |=>
        !o_user_mode && !o_sleep_allow) else $error("entry state wrong");
    AST_RFI_GO: assert property (i_rfi && !i_exc_take |=> o_rfi_go)
        else $error("return not signalled");
    AST_RFI_PC: assert property (
        i_exc_take && !i_acc_valid ##1 i_rfi && !i_exc_take && !i_acc_valid
        |=> o_rfi_pc == $past(i_exc_addr, 2))
        else $error("return address wrong");
    AST_TB_TICK: assert property (tbl_rd ##1 tbl_rd |=>
        o_acc_rdata == $past(o_acc_rdata) + 32'h1)
        else $error("time base not counting");
    AST_VERSION: assert property (
        spr_rd && i_acc_num == `PRS_SPR_PVR && !o_user_mode
        |=> o_acc_rdata == VERSION_ID) else $error("version read wrong");
    COV_FAULT: cover property (o_priv_fault);
    COV_RFI: cover property (o_rfi_go);
    COV_CTR: cover property (o_ctr_zero);
endmodule // prs_register_set_sva
bind prs_register_set prs_register_set_sva #(.VERSION_ID(VERSION_ID))
    i_prs_register_set_sva (.*);
`default_nettype wire

// file: prs_exc_model.sv
// exception logic model driving entry and return pulses
`timescale 1ns/1ns
`default_nettype none
module prs_exc_model (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_go_exc,
    input wire logic i_go_rfi,
    input wire logic [31:0] i_pc,
    output logic o_exc_take = 1'b0,
    output logic o_rfi = 1'b0,
    output logic [31:0] o_exc_addr = 32'h0
);
    always @(posedge i_ref_clk) begin
        o_exc_take <= i_go_exc && !i_rst;
        o_rfi <= i_go_rfi && !i_rst;
        // address only meaningful with the entry pulse
        o_exc_addr <= i_go_exc ? i_pc : ~o_exc_addr;
    end
endmodule // prs_exc_model
`default_nettype wire

// file: processor_register_set_bench.sv
// self-checking bench for the processor register set
`timescale 1ns/1ns
`default_nettype none
`include "prs_consts.vh"
`define NE @(negedge i_ref_clk)
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
$display("[ERR] %0t got %h want %h", $time, a, b); end end
module processor_register_set_bench;
    localparam [31:0] VID = 32'h0000_1234; // arbitrary value
    logic i_ref_clk = 0, i_rst = 1, i_acc_valid = 0, i_acc_write = 0;
    logic i_gpr_we = 0, i_fpr_we = 0, i_cr_we = 0, i_xer_we = 0;
    logic i_xer_ov = 0, i_xer_ca = 0, i_xer_bc_we = 0, i_float_status_control_we = 0;
    logic i_link_we = 0, i_bc_dec = 0, i_dfault = 0, go_exc = 0, go_rfi = 0;
    logic [1:0] i_acc_kind = 0;
    logic [9:0] i_acc_num = 0;
    logic [31:0] i_acc_wdata = 0, i_gpr_wd = 0, i_float_status_control_wd = 0, exc_pc = 0;
    logic [31:0] i_link_addr = 0, i_dfault_addr = 0, i_dfault_cause = 0;
    logic [4:0] i_gpr_ra = 0, i_gpr_rb = 0, i_gpr_wa = 0;
    logic [4:0] i_fpr_ra = 0, i_fpr_wa = 0;
    logic [63:0] i_fpr_wd = 0;
    logic [2:0] i_cr_field = 0;
    logic [3:0] i_cr_val = 0, i_data_seg = 0, i_fetch_seg = 0;
    logic [6:0] i_xer_bc = 0;
    wire logic i_exc_take, i_rfi, o_acc_done, o_priv_fault, o_acc_illegal;
    wire logic o_ctr_zero, o_rfi_go, o_user_mode, o_sleep_allow, o_perf_mark;
    wire logic o_ext_access_en, o_dec_exc;
    wire logic [31:0] i_exc_addr, o_acc_rdata, o_gpr_a, o_gpr_b, o_cr, o_xer;
    wire logic [31:0] o_float_status_control, o_link, o_rfi_pc, o_msr, o_data_seg, o_fetch_seg;
    wire logic [63:0] o_fpr_a;
    logic [31:0] rd, v, w, gx [32], sx [16];
    logic [63:0] fx [32];
    logic flt, ill;
    int i, err_total = 0, n_tests = 0;
    prs_register_set #(.VERSION_ID(VID)) i_prs_register_set (.*);
    prs_exc_model i_prs_exc_model (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_go_exc(go_exc), .i_go_rfi(go_rfi), .i_pc(exc_pc),
        .o_exc_take(i_exc_take), .o_rfi(i_rfi), .o_exc_addr(i_exc_addr));
    always #25 i_ref_clk = ~i_ref_clk;
    task automatic acc(input logic wr, input logic [1:0] k,
            input logic [9:0] n, input logic [31:0] d);
        i_acc_valid = 1;
        i_acc_write = wr;
        i_acc_kind = k;
        i_acc_num = n;
        i_acc_wdata = d;
        `NE;
        i_acc_valid = 0;
        rd = o_acc_rdata;
        flt = o_priv_fault;
        ill = o_acc_illegal;
        `CHK(o_acc_done, 1'b1)
        `NE;
    endtask
    task automatic kick(input logic e, input logic [31:0] a);
        go_exc = e;
        go_rfi = !e;
        exc_pc = a;
        `NE;
        go_exc = 0;
        go_rfi = 0;
        `NE;
    endtask
    function automatic logic [9:0] sup_spr(input int k);
        if (k < 16) return `PRS_SPR_BAT_LO + k[9:0];
        if (k < 20) return `PRS_SPR_SPRG0 + k[9:0] - 10'h010;
        return (k == 20) ? `PRS_SPR_PAGE_TABLE_DESCRIPTOR : `PRS_SPR_DATA_WATCH_ADDRESS;
    endfunction
    function automatic logic [31:0] xer_want(input logic so, ov, ca,
            input logic [6:0] bc);
        xer_want = 32'h0000_0000;
        xer_want[`PRS_XER_SO] = so;
        xer_want[`PRS_XER_OV] = ov;
        xer_want[`PRS_XER_CA] = ca;
        xer_want[6:0] = bc;
    endfunction
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #(50 * 4000);
        err_total++;
        report_and_stop;
    end
    initial begin
        v = $urandom(32'h9FA6);
        repeat (8) @(posedge i_ref_clk);
        `NE;
        i_rst = 0;
        `NE;
        acc(1, `PRS_ACC_SPR, `PRS_SPR_PVR, $urandom);
        acc(0, `PRS_ACC_SPR, `PRS_SPR_PVR, 0);
        `CHK(rd, VID)
        w = 0;
        for (i = 0; i < 8; i++) begin
            v = $urandom;
            i_cr_field = i[2:0];
            i_cr_val = v[3:0];
            i_cr_we = 1;
            w[4*i +: 4] = v[3:0];
            `NE;
        end
        i_cr_we = 0;
        acc(0, `PRS_ACC_CR, 0, 0);
        `CHK(rd, w)
        for (i = 0; i < 32; i++) begin
            gx[i] = $urandom;
            fx[i] = {$urandom, $urandom};
            i_gpr_wa = i[4:0];
            i_gpr_wd = gx[i];
            i_gpr_we = 1;
            i_fpr_wa = i[4:0];
            i_fpr_wd = fx[i];
            i_fpr_we = 1;
            `NE;
        end
        i_gpr_we = 0;
        i_fpr_we = 0;
        for (i = 31; i >= 0; i--) begin
            i_gpr_ra = i[4:0];
            i_gpr_rb = ~i[4:0];
            i_fpr_ra = i[4:0];
            `NE;
            `CHK(o_gpr_a, gx[i])
            `CHK(o_gpr_b, gx[31-i])
            `CHK(o_fpr_a, fx[i])
        end
        for (i = 0; i < 16; i++) begin
            sx[i] = $urandom;
            acc(1, `PRS_ACC_SEG, i[9:0], sx[i]);
        end
        for (i = 0; i < 16; i++) begin
            i_data_seg = i[3:0];
            i_fetch_seg = 4'hF - i[3:0];
            acc(0, `PRS_ACC_SEG, i[9:0], 0);
            `CHK(rd, sx[i])
            `CHK(o_data_seg, sx[i])
            `CHK(o_fetch_seg, sx[15-i])
        end
        for (i = 0; i < 22; i++) begin
            v = $urandom;
            acc(1, `PRS_ACC_SPR, sup_spr(i), v);
            acc(0, `PRS_ACC_SPR, sup_spr(i), 0);
            `CHK(rd, v)
            `CHK(rd[31:16], v[31:16])
        end
        acc(1, `PRS_ACC_SPR, 10'h3FF, 32'hFFFF_FFFF);
        `CHK({ill, flt}, 2'h2)
        acc(1, `PRS_ACC_SPR, `PRS_SPR_CTR, 1);
        i_bc_dec = 1;
        `NE;
        i_bc_dec = 0;
        `CHK(o_ctr_zero, 1'b1)
        v = $urandom;
        w = $urandom;
        i_link_addr = v;
        i_link_we = 1;
        i_dfault_addr = w;
        i_dfault_cause = ~w;
        i_dfault = 1;
        i_float_status_control_wd = v ^ w;
        i_float_status_control_we = 1;
        i_xer_ov = 1;
        i_xer_we = 1;
        i_xer_bc = w[6:0];
        i_xer_bc_we = 1;
        `NE;
        i_xer_ov = 0;
        i_xer_ca = 1;
        i_link_we = 0;
        i_dfault = 0;
        i_float_status_control_we = 0;
        i_xer_bc_we = 0;
        `NE;
        i_xer_we = 0;
        `CHK(o_float_status_control, v ^ w)
        `CHK(o_xer, xer_want(1, 0, 1, w[6:0]))
        acc(0, `PRS_ACC_SPR, `PRS_SPR_DAR, 0);
        `CHK(rd, w)
        acc(0, `PRS_ACC_SPR, `PRS_SPR_DATA_FAULT_CAUSE, 0);
        `CHK(rd, ~w)
        acc(0, `PRS_ACC_SPR, `PRS_SPR_LR, 0);
        `CHK(rd, v)
        `CHK(o_link, v)
        acc(1, `PRS_ACC_SPR, `PRS_SPR_DEC, 32'h14);
        for (i = 0; i < 40 && o_dec_exc !== 1'b1; i++) `NE;
        `CHK(o_dec_exc && i == 20, 1'b1)
        acc(1, `PRS_ACC_SPR, `PRS_SPR_TBU_W, w);
        acc(1, `PRS_ACC_SPR, `PRS_SPR_SPRG0, v);
        acc(1, `PRS_ACC_SPR, `PRS_SPR_EAR, 32'h8000_0000);
        `CHK(o_ext_access_en, 1'b1)
        acc(1, `PRS_ACC_MSR, 0, 32'h0004_4004);
        `CHK({o_sleep_allow, o_user_mode, o_perf_mark}, 3'h7)
        `CHK(o_msr, 32'h0004_4004)
        acc(1, `PRS_ACC_SPR, `PRS_SPR_SPRG0, ~v);
        `CHK(flt, 1'b1)
        acc(1, `PRS_ACC_SPR, `PRS_SPR_TBU_W, ~w);
        `CHK(flt, 1'b1)
        acc(0, `PRS_ACC_MSR, 0, 0);
        `CHK(flt, 1'b1)
        i_acc_num = `PRS_SPR_TBL_R;
        i_acc_kind = `PRS_ACC_SPR;
        i_acc_valid = 1;
        `NE;
        rd = o_acc_rdata;
        `NE;
        i_acc_valid = 0;
        `CHK({o_priv_fault, o_acc_rdata}, {1'b0, rd + 32'h1})
        `NE;
        kick(1, v ^ w);
        `CHK({o_sleep_allow, o_user_mode}, 2'h0)
        acc(0, `PRS_ACC_SPR, `PRS_SPR_RESUME_STATE_SAVE, 0);
        `CHK(rd, 32'h0004_4004)
        acc(0, `PRS_ACC_SPR, `PRS_SPR_SPRG0, 0);
        `CHK(rd, v)
        acc(0, `PRS_ACC_SPR, `PRS_SPR_TBU_R, 0);
        `CHK(rd, w)
        kick(0, 0);
        `CHK({o_rfi_go, o_user_mode, o_rfi_pc}, {2'h3, v ^ w})
        go_exc = 1;
        exc_pc = ~v;
        `NE;
        go_exc = 0;
        go_rfi = 1;
        `NE;
        go_rfi = 0;
        `NE;
        `CHK(o_rfi_pc, ~v)
        report_and_stop;
    end
endmodule // processor_register_set_bench
`default_nettype wire
